// *** rtl/aux_clk_pkg.sv ***
`default_nettype none
package aux_clk_pkg;

  // Function currently driven on one auxiliary pin
  typedef enum logic [2:0] {
    FN_OFF  = 3'b000,
    FN_REF  = 3'b001,
    FN_DIV2 = 3'b010,
    FN_DIV4 = 3'b011,
    FN_OVR  = 3'b100
  } pin_func_t;

  // Control word written by software
  typedef struct packed {
    logic [21:0] rsv_hi;
    logic [1:0]  out_d_div_select;
    logic [1:0]  rsv_mid;
    logic [1:0]  out_c_div_select;
    logic [1:0]  rsv_lo;
    logic        overrange_out_enable;
    logic        strap_override_enable;
  } ctrl_reg_t;

  // Status word read back by software
  typedef struct packed {
    logic [18:0] rsv_hi;
    logic        power_down;
    logic [1:0]  rsv_mid;
    logic [1:0]  straps;
    logic        rsv_lo;
    pin_func_t   func_d;
    logic        rsv_c;
    pin_func_t   func_c;
  } status_reg_t;

endpackage : aux_clk_pkg
`default_nettype wire

// *** rtl/aux_clk_regs.svh ***
`ifndef AUX_CLK_REGS_SVH
`define AUX_CLK_REGS_SVH

// Register byte addresses (AXI4-Lite, one word each)
`define ADDR_CTRL     4'h0
`define ADDR_STATUS   4'h4
`define ADDR_MSB      3
`define CTRL_RESET    32'h0000_0000
`define CTRL_MASK     32'h0000_0333

// Bus responses
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

// Strap and mode codes
`define CODE_NONE     2'h0
`define CODE_REF      2'h1

// Divider phase counter
`define CNT_ZERO      2'h0
`define CNT_ONE       2'h1
`define CNT_LAST      2'h3

`endif

// *** rtl/aux_ref_clock_output_select.sv ***
// Functional notes
// - Both aux pins can carry the reference clock via straps or registers.
// - Strap-selected clocks run from power-up while power-down stays low.
// - Power-down high turns both aux outputs off.
// - With override bit set, register modes replace straps; else modes ignored.
// - Straps set divider for output C only; output D only on or off.
// - A selected clock function beats the over-range function.
// - Output D clock only works when output C has a nonzero clock mode.
// - Output C: codes 1,2,3 give ref, ref/2, ref/4; zero falls to over-range.
// - Output D: nonzero strap gives ref; modes 1,2,3 give ref, /2, /4.
// - No clock: over-range on either pin if enabled on quad part, else disabled.
`include "aux_clk_regs.svh"
`default_nettype none
module aux_ref_clock_output_select (
  // Clock and reset
  input  wire  logic                   ref_clk_i,
  input  wire  logic                   rst_i,
  // Board pins
  input  wire  logic [1:0]             clk_cfg_straps_i,
  input  wire  logic                   power_down_pin_i,
  input  wire  logic                   quad_part_i,
  input  wire  logic                   overrange_c_i,
  output logic                         aux_clk_out_c_o,
  output logic                         aux_clk_out_d_o,
  output var aux_clk_pkg::pin_func_t   func_c_o,
  // AXI4-Lite write
  input  wire  logic [`ADDR_MSB:0]     s_axi_awaddr_i,
  input  wire  logic                   s_axi_awvalid_i,
  output logic                         s_axi_awready_o,
  input  wire  logic [31:0]            s_axi_wdata_i,
  input  wire  logic [3:0]             s_axi_wstrb_i,
  input  wire  logic                   s_axi_wvalid_i,
  output logic                         s_axi_wready_o,
  output logic [1:0]                   s_axi_bresp_o,
  output logic                         s_axi_bvalid_o,
  input  wire  logic                   s_axi_bready_i,
  // AXI4-Lite read
  input  wire  logic [`ADDR_MSB:0]     s_axi_araddr_i,
  input  wire  logic                   s_axi_arvalid_i,
  output logic                         s_axi_arready_o,
  output logic [31:0]                  s_axi_rdata_o,
  output logic [1:0]                   s_axi_rresp_o,
  output logic                         s_axi_rvalid_o,
  input  wire  logic                   s_axi_rready_i
);
  import aux_clk_pkg::*;

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  ctrl_reg_t          ctrl_q;
  logic [`ADDR_MSB:0] awaddr_q;
  logic               aw_full_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               w_full_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               rvalid_q;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;
  logic [31:0]        wr_merged;
  status_reg_t        status;

  wire do_write = aw_full_q && w_full_q && !bvalid_q;
  wire wr_ctrl  = do_write && (awaddr_q == `ADDR_CTRL);
  wire wr_stat  = do_write && (awaddr_q == `ADDR_STATUS);
  wire wr_hit   = wr_ctrl || wr_stat;
  wire rd_take  = s_axi_arvalid_i && !rvalid_q;
  wire rd_ctrl  = (s_axi_araddr_i == `ADDR_CTRL);
  wire rd_stat  = (s_axi_araddr_i == `ADDR_STATUS);

  assign s_axi_awready_o = !aw_full_q;
  assign s_axi_wready_o  = !w_full_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  // Byte lanes merge into the current control word
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_merged[8*b+:8] = wstrb_q[b] ? wdata_q[8*b+:8] : ctrl_q[8*b+:8];
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Status is read-only: writes to it are accepted and dropped
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wr_merged & `CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_ctrl ? ctrl_q : (rd_stat ? status : '0);
      rresp_q  <= (rd_ctrl || rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture and function selection
  // ----------------------------------------------------------------
  logic [1:0] straps_q;
  logic       ovr_in_q;

  // Straps are followed while reset is held and frozen at its release
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      straps_q <= clk_cfg_straps_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ovr_in_q <= 1'b0;
    end else begin
      ovr_in_q <= overrange_c_i;
    end
  end

  wire       override = ctrl_q.strap_override_enable;
  wire [1:0] code_c   = override ? ctrl_q.out_c_div_select : straps_q;
  wire       strap_on = (straps_q != `CODE_NONE);
  wire [1:0] code_d   = override ? ctrl_q.out_d_div_select
                      : (strap_on ? `CODE_REF : `CODE_NONE);
  wire       clk_c    = (code_c != `CODE_NONE);
  wire       clk_d    = (code_d != `CODE_NONE) && clk_c;
  wire       ovr_ok   = ctrl_q.overrange_out_enable && quad_part_i;

  pin_func_t fallback;
  pin_func_t next_c;
  pin_func_t next_d;

  assign fallback = ovr_ok ? FN_OVR : FN_OFF;
  assign next_c = power_down_pin_i ? FN_OFF
                : (clk_c ? pin_func_t'({1'b0, code_c}) : fallback);
  assign next_d = power_down_pin_i ? FN_OFF
                : (clk_d ? pin_func_t'({1'b0, code_d}) : fallback);

  // ----------------------------------------------------------------
  // Divider and glitch-free output stage
  // ----------------------------------------------------------------
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  pin_func_t  func_q [2];
  logic       pin_q  [2];
  logic       gate_q [2];
  logic       pin_o  [2];

  // New functions only take effect at the end of a /4 period, when both
  // divided waves are about to restart low, so no shortened pulse appears
  wire tick = (cnt_q == `CNT_LAST);
  assign cnt_d = cnt_q + `CNT_ONE;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= `CNT_LAST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_pin
    wire pin_func_t sel = (p == 0) ? next_c : next_d;
    logic           wave;
    // A high level left over from over-range must not run into a new wave
    wire            restart = tick && (sel != func_q[p]);

    always_comb begin
      case (func_q[p])
        FN_DIV2: wave = cnt_d[0];
        FN_DIV4: wave = cnt_d[1];
        FN_OVR:  wave = ovr_in_q;
        default: wave = 1'b0;
      endcase
    end

    // Reset leaves the strap choice to load at the first tick
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        func_q[p] <= FN_OFF;
        pin_q[p]  <= 1'b0;
      end else begin
        if (tick) begin
          func_q[p] <= sel;
        end
        pin_q[p] <= restart ? 1'b0 : wave;
      end
    end

    // Gate enable moves only while the clock is low
    always_ff @(negedge ref_clk_i) begin
      if (rst_i) begin
        gate_q[p] <= 1'b0;
      end else begin
        gate_q[p] <= (func_q[p] == FN_REF);
      end
    end

    assign pin_o[p] = (ref_clk_i && gate_q[p]) || pin_q[p];
  end

  assign aux_clk_out_c_o = pin_o[0];
  assign aux_clk_out_d_o = pin_o[1];
  assign func_c_o        = func_q[0];

  always_comb begin
    status             = '0;
    status.func_c      = func_q[0];
    status.func_d      = func_q[1];
    status.straps      = straps_q;
    status.power_down  = power_down_pin_i;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_POWERUP_RUN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($fell(rst_i) && (straps_q != `CODE_NONE) && !power_down_pin_i && !override)
    |-> ##[1:5] (func_q[0] != FN_OFF))
    else $error("Strap clock not running after reset");

  AST_PD_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    power_down_pin_i [*5] |-> (func_q[0] == FN_OFF) && (func_q[1] == FN_OFF))
    else $error("Outputs active while powered down");

  AST_OVERRIDE_MODE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick && !power_down_pin_i && override && ctrl_q.out_c_div_select == 2'h3)
    |=> (func_q[0] == FN_DIV4))
    else $error("Register mode 3 did not give ref/4");

  AST_STRAP_D_UNDIV: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick && !power_down_pin_i && !override && strap_on) |=> (func_q[1] == FN_REF))
    else $error("Strap did not give undivided ref on D");

  AST_CLK_PRIO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick && !power_down_pin_i && clk_c && ctrl_q.overrange_out_enable)
    |=> (func_q[0] != FN_OVR))
    else $error("Over-range beat a selected clock");

  AST_D_NEEDS_C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (func_q[1] inside {FN_REF, FN_DIV2, FN_DIV4})
    |-> (func_q[0] inside {FN_REF, FN_DIV2, FN_DIV4}))
    else $error("D clock without C clock");

  AST_STRAP_C_DIV2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick && !power_down_pin_i && !override && straps_q == 2'h2) |=> (func_q[0] == FN_DIV2))
    else $error("Strap code 2 did not give ref/2");

  AST_FALLBACK_OVR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick && !power_down_pin_i && !clk_c && ctrl_q.overrange_out_enable && quad_part_i)
    |=> (func_q[0] == FN_OVR) ##1 (pin_q[0] == $past(ovr_in_q)))
    else $error("Over-range fallback missing");

  AST_DIV2_WAVE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (func_q[0] == FN_DIV2 && $past(func_q[0]) == FN_DIV2)
    |-> (pin_q[0] != $past(pin_q[0])))
    else $error("Divide-by-2 wave did not toggle");

endmodule : aux_ref_clock_output_select
`default_nettype wire

// *** verification/aux_clk_sink.sv ***
`default_nettype none
module aux_clk_sink (
  // Auxiliary pins from the converter
  input  wire logic clk_c_i,
  input  wire logic clk_d_i,
  // Rising edges seen so far
  output var  int   edges_c_o,
  output var  int   edges_d_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Board logic takes pin C for a single clock, pin D only beside it
  always @(posedge clk_c_i) edges_c_o <= edges_c_o + 1;
  always @(posedge clk_d_i) edges_d_o <= edges_d_o + 1;
endmodule : aux_clk_sink
`default_nettype wire

// *** verification/aux_ref_clock_output_select_tb.sv ***
`include "aux_clk_regs.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module aux_ref_clock_output_select_tb;
  import aux_clk_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, pd, quad, ovr_in, awvalid, wvalid, bready, arvalid, rready;
  logic [1:0] straps, bresp, rresp;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, c_pin, d_pin;
  logic [1:0] r;
  pin_func_t func_c;
  int edges_c, edges_d, err_total, checks;
  int m_straps, m_ovr, m_oen, m_cs, m_ds, m_pd, m_quad;

  aux_ref_clock_output_select u_dut (.ref_clk_i(ref_clk), .rst_i(rst),
    .clk_cfg_straps_i(straps), .power_down_pin_i(pd), .quad_part_i(quad),
    .overrange_c_i(ovr_in), .aux_clk_out_c_o(c_pin), .aux_clk_out_d_o(d_pin),
    .func_c_o(func_c), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  aux_clk_sink u_sink (.clk_c_i(c_pin), .clk_d_i(d_pin), .edges_c_o(edges_c),
    .edges_d_o(edges_d));

  // ----------------------------------------
  // Clock, over-range pattern, watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Toggling flag gives an over-range pin a known edge rate
  always @(posedge ref_clk) ovr_in <= ~ovr_in;
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic int mode_c();
    return m_ovr ? m_cs : m_straps;
  endfunction : mode_c
  function automatic int eff_c();
    if (m_pd) return 0;
    if (mode_c() != 0) return mode_c();
    return (m_oen && m_quad) ? 4 : 0;
  endfunction : eff_c
  function automatic int eff_d();
    int md;
    md = m_ovr ? m_ds : int'(m_straps != 0);
    if (m_pd) return 0;
    if (mode_c() != 0 && md != 0) return md;
    return (m_oen && m_quad) ? 4 : 0;
  endfunction : eff_d
  function automatic int edge_cnt(input int f);
    case (f)
      1: return 64;
      2, 4: return 32;
      3: return 16;
      default: return 0;
    endcase
  endfunction : edge_cnt

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw_done, w_done;
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (!aw_done && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge ref_clk);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // Entered at time zero or on a rising edge, so reset is seen for exactly 3 edges
  task automatic do_reset(input int s);
    rst <= 1'b1;
    straps <= 2'(s);
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    m_straps = s;
    {m_ovr, m_oen, m_cs, m_ds} = '0;
  endtask : do_reset
  task automatic set_ctrl(input int ov, input int oe, input int cs, input int ds);
    ctrl_reg_t c;
    c = '0;
    c.strap_override_enable = 1'(ov);
    c.overrange_out_enable = 1'(oe);
    c.out_c_div_select = 2'(cs);
    c.out_d_div_select = 2'(ds);
    axi_wr(`ADDR_CTRL, c, r);
    `CHK("ctrl_bresp", `RESP_OKAY, r)
    {m_ovr, m_oen, m_cs, m_ds, m_quad} = {ov, oe, cs, ds, int'($urandom % 2)};
    quad <= 1'(m_quad);
  endtask : set_ctrl
  task automatic check_all();
    int ec, ed, c0, d0;
    status_reg_t st;
    ec = eff_c();
    ed = eff_d();
    repeat (12) @(posedge ref_clk);
    `CHK("func_c", 3'(ec), func_c)
    axi_rd(`ADDR_STATUS, d, r);
    st = d;
    `CHK("func_d", 3'(ed), st.func_d)
    `CHK("straps", 2'(m_straps), st.straps)
    `CHK("pd", 1'(m_pd), st.power_down)
    @(negedge ref_clk);
    {c0, d0} = {edges_c, edges_d};
    repeat (64) @(negedge ref_clk);
    `CHK("edges_c", edge_cnt(ec), edges_c - c0)
    `CHK("edges_d", edge_cnt(ed), edges_d - d0)
    @(posedge ref_clk);
  endtask : check_all
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {pd, quad, ovr_in, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {err_total, checks, m_pd, m_quad} = '0;
    void'($urandom(11));
    do_reset(0);
    axi_rd(`ADDR_CTRL, d, r);
    `CHK("ctrl_reset", `CTRL_RESET, d)
    for (int s = 0; s < 4; s++) begin
      do_reset(s);
      check_all();
      set_ctrl(0, $urandom % 2, $urandom % 4, $urandom % 4);
      check_all();
    end
    $display("strap test done");
    for (int i = 0; i < 16; i++) begin
      set_ctrl(1, $urandom % 2, i % 4, i / 4);
      check_all();
    end
    $display("override test done");
    pd <= 1'b1;
    m_pd = 1;
    check_all();
    pd <= 1'b0;
    m_pd = 0;
    check_all();
    $display("power down test done");
    axi_wr(`ADDR_CTRL, 32'hffff_ffff, r);
    {m_ovr, m_oen, m_cs, m_ds} = {32'sd1, 32'sd1, 32'sd3, 32'sd3};
    axi_rd(`ADDR_CTRL, d, r);
    `CHK("ctrl_mask", `CTRL_MASK, d)
    axi_wr(`ADDR_STATUS, 32'h0, r);
    `CHK("status_wr", `RESP_OKAY, r)
    check_all();
    axi_wr(4'h8, 32'h0, r);
    `CHK("unmapped_wr", `RESP_SLVERR, r)
    axi_rd(4'hc, d, r);
    `CHK("unmapped_rd", {`RESP_SLVERR, 32'h0}, {r, d})
    $display("bus test done");
    finish_test();
  end
endmodule : aux_ref_clock_output_select_tb
`default_nettype wire
